// [hw/afc_consts.vh]
// Shared constants of the axis feedback counter: timing, offsets, fields, resets
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AFC_CLK_PERIOD_NS 5
`define AFC_SQ_MAX_HZ 200000
`define AFC_SINE_MAX_HZ 25000
`define AFC_SQ_EDGE_GAP_NS 450
// Sine gap scales the square gap by the ratio of the two rate limits
`define AFC_SINE_EDGE_GAP_NS (`AFC_SQ_EDGE_GAP_NS * `AFC_SQ_MAX_HZ / `AFC_SINE_MAX_HZ)
`define AFC_SQ_GAP_CYC ((`AFC_SQ_EDGE_GAP_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_SINE_GAP_CYC ((`AFC_SINE_EDGE_GAP_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_SINE_FACTOR 5

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AFC_OFS_CTRL 8'h00
`define AFC_OFS_MOVE 8'h04
`define AFC_OFS_STAT 8'h08
`define AFC_OFS_PCLR 8'h0C
`define AFC_OFS_AXCFG 8'h10
`define AFC_OFS_AXPOS 8'h40
`define AFC_OFS_SPPOS 8'h34
`define AFC_OFS_HWPOS 8'h38

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define AFC_CTRL_SEL_LO 0
`define AFC_CTRL_V_EN 2
`define AFC_CTRL_ROUTE_LO 4
`define AFC_CTRL_SE_SET 6
`define AFC_CFG_SINE 0
`define AFC_CFG_X2 1
`define AFC_CFG_INCH 2
`define AFC_CFG_EXTRA 3
`define AFC_CFG_RES_LO 8
`define AFC_STAT_ILLEGAL 8
`define AFC_STAT_V_ON 9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AFC_RST_CTRL 8'h00
`define AFC_RST_CFG 16'h0100
`define AFC_RST_MOVE 5'h00

`endif

// [hw/afc_pos_acc.v]
// Signed position accumulator stepping by a programmable increment
module afc_pos_acc (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_step,
   input wire i_dir,
   input wire i_clr,
   input wire [19:0] i_inc,
   output reg [31:0] o_pos
);
   wire [31:0] inc_ext = {12'h000, i_inc};

   // ----------------------------------------------------------------------
   // Accumulate; clear takes priority over a coincident step
   // ----------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n || i_clr)
         o_pos <= 32'h0000_0000;
      else if (i_step && i_dir)
         o_pos <= o_pos + inc_ext;
      else if (i_step)
         o_pos <= o_pos - inc_ext;
   end
endmodule

// [hw/afc_pos_acc_unused_guard.v]
// Holds no logic; the accumulator lives in afc_pos_acc.v

// [hw/afc_quad_dec.v]
// Quadrature decoder with x2/x4 edge selection and edge spacing monitor
`include "afc_consts.vh"

module afc_quad_dec #(
   parameter GAP_SQ = `AFC_SQ_GAP_CYC,
   parameter GAP_SINE = `AFC_SINE_GAP_CYC
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_a,
   input wire i_b,
   input wire i_sine,
   input wire i_x2,
   output reg o_step,
   output reg o_dir,
   output reg o_err
);
   reg a_meta_reg, a_sync_reg, a_prev_reg;
   reg b_meta_reg, b_sync_reg, b_prev_reg;
   reg [9:0] gap_reg;
   wire a_chg = a_sync_reg ^ a_prev_reg;
   wire b_chg = b_sync_reg ^ b_prev_reg;
   wire any_chg = a_chg | b_chg;
   wire [9:0] gap_lim = i_sine ? GAP_SINE[9:0] : GAP_SQ[9:0];
   // A leading B counts up; direction comes from which channel moved
   wire fwd = a_chg ? (a_sync_reg ^ b_sync_reg) : ~(a_sync_reg ^ b_sync_reg); // [RL15]

   // --------------------------------------------------------------------
   // Pin synchronisers, edge history and gap counter
   // --------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         a_meta_reg <= 1'b0;
         a_sync_reg <= 1'b0;
         a_prev_reg <= 1'b0;
         b_meta_reg <= 1'b0;
         b_sync_reg <= 1'b0;
         b_prev_reg <= 1'b0;
         gap_reg <= 10'h3FF;
         o_step <= 1'b0;
         o_dir <= 1'b0;
         o_err <= 1'b0;
      end else begin
         a_meta_reg <= i_a;
         a_sync_reg <= a_meta_reg;
         a_prev_reg <= a_sync_reg;
         b_meta_reg <= i_b;
         b_sync_reg <= b_meta_reg;
         b_prev_reg <= b_sync_reg;
         // Saturating count of cycles since the last edge
         if (any_chg)
            gap_reg <= 10'h001;
         else if (gap_reg != 10'h3FF)
            gap_reg <= gap_reg + 10'h001;
         // x4 takes every edge of either channel that changes alone, x2 both edges of A only
         o_step <= (a_chg ^ b_chg) & (a_chg | ~i_x2); // [RL9] [RL15]
         o_dir <= fwd;
         // Edges too close or both channels at once mean overspeed
         o_err <= (any_chg & (gap_reg < gap_lim)) | (a_chg & b_chg); // [RL7] [RL8]
      end
   end
endmodule

// [hw/afc_top.v]
// Axis feedback counter: six feedback inputs, axis routing, AXI4-Lite registers
//
// Overview of operation
// [RL1] Inputs one to four feed X, Y, Z, W
// [RL2] Input five: square wave, V, spindle or handwheel
// [RL3] Input six: single-ended, spindle or handwheel
// [RL4] Only four routings; first four fixed
// [RL5] At most three axes; W, V exclusions
// [RL6] V axis only when fifth axis enabled
// [RL7] Sine counting limited to 25 kHz
// [RL8] Square 200 kHz, 450 ns edge spacing
// [RL9] Multiply setting: 0 gives x4, 1 x2
// [RL10] Sine feedback adds fixed x5 interpolation
// [RL11] Extra sine multiply: resolution taken literally
// [RL12] Feedback type selects sine or square
// [RL13] Units setting: millimetres or inches
// [RL14] Counting resolution sets smallest displacement step
// [RL15] Direction from A/B phase order
// [RL16] Spindle pulses always counted times four
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "afc_consts.vh"

module afc_top #(
   parameter GAP_SQ = `AFC_SQ_GAP_CYC,
   parameter GAP_SINE = `AFC_SINE_GAP_CYC
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [5:0] i_fb_a,
   input wire [5:0] i_fb_b,
   input wire [7:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [7:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   output reg [4:0] o_axis_move_en,
   output reg [4:0] o_axis_inch,
   output reg o_interp_illegal,
   output reg [5:0] o_overspeed
);
   localparam RESP_OK = 2'b00;
   localparam RESP_ERR = 2'b10;
   localparam [19:0] SINE_MUL = `AFC_SINE_FACTOR;

   // --------------------------------------------------------------------
   // Configuration and status storage
   // --------------------------------------------------------------------
   reg [7:0] ctrl_reg;
   reg [4:0] move_reg;
   reg [5:0] err_reg;
   reg [6:0] pclr_reg;
   reg [15:0] cfg_reg [0:4];
   reg [7:0] aw_addr_reg;
   reg aw_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_full_reg;

   wire [1:0] sel = ctrl_reg[`AFC_CTRL_SEL_LO +: 2];
   wire [1:0] route = ctrl_reg[`AFC_CTRL_ROUTE_LO +: 2];
   wire v_en = ctrl_reg[`AFC_CTRL_V_EN];
   // Input five reaches V only in the two V routings and with V enabled
   wire v_on = v_en & ~route[1]; // [RL4] [RL6]

   // --------------------------------------------------------------------
   // Decoders, one per feedback input
   // --------------------------------------------------------------------
   wire [5:0] dec_step;
   wire [5:0] dec_dir;
   wire [5:0] dec_err;
   genvar k;
   generate
      for (k = 0; k < 6; k = k + 1) begin : g_dec
         // Only the first four inputs may carry sine; input five's x2 is V's
         wire sine_k = (k < 4) ? cfg_reg[k & 3][`AFC_CFG_SINE] : 1'b0; // [RL1] [RL2] [RL12]
         wire x2_k = (k < 4) ? cfg_reg[k & 3][`AFC_CFG_X2] :
            (k == 4) ? (v_on & cfg_reg[4][`AFC_CFG_X2]) : 1'b0; // [RL9] [RL16]
         afc_quad_dec #(
            .GAP_SQ(GAP_SQ),
            .GAP_SINE(GAP_SINE)
         ) u_dec (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_a(i_fb_a[k]),
            .i_b(i_fb_b[k]),
            .i_sine(sine_k),
            .i_x2(x2_k),
            .o_step(dec_step[k]),
            .o_dir(dec_dir[k]),
            .o_err(dec_err[k])
         );
      end
   endgenerate

   // --------------------------------------------------------------------
   // Axis position counters X, Y, Z, W, V
   // --------------------------------------------------------------------
   wire [31:0] ax_pos [0:4];
   generate
      for (k = 0; k < 5; k = k + 1) begin : g_ax
         wire [15:0] res_k = {8'h00, cfg_reg[k][`AFC_CFG_RES_LO +: 8]};
         // Sine edges carry five sub-counts; with the extra factor the
         // resolution field is the sub-count size, so one edge is five of them
         wire extra_k = (k < 4) & cfg_reg[k][`AFC_CFG_SINE] & cfg_reg[k][`AFC_CFG_EXTRA];
         wire [19:0] inc_k = extra_k ? ({4'h0, res_k} * SINE_MUL) :
            {4'h0, res_k}; // [RL10] [RL11] [RL14]
         wire step_k = (k < 4) ? dec_step[k] : (dec_step[4] & v_on); // [RL6]
         afc_pos_acc u_acc (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_step(step_k),
            .i_dir(dec_dir[k]),
            .i_clr(pclr_reg[k]),
            .i_inc(inc_k),
            .o_pos(ax_pos[k])
         );
      end
   endgenerate

   // --------------------------------------------------------------------
   // Spindle and handwheel routing between inputs five and six
   // --------------------------------------------------------------------
   // Routing 0: V/spindle, 1: V/handwheel, 2: spindle/handwheel, 3: handwheel/spindle
   wire sp_from5 = (route == 2'd2); // [RL4]
   wire hw_from5 = (route == 2'd3); // [RL4]
   wire sp_active = (route != 2'd1); // [RL3]
   wire hw_active = (route != 2'd0); // [RL3]
   wire sp_step = sp_active & (sp_from5 ? dec_step[4] : dec_step[5]);
   wire sp_dir = sp_from5 ? dec_dir[4] : dec_dir[5];
   wire hw_step = hw_active & (hw_from5 ? dec_step[4] : dec_step[5]);
   wire hw_dir = hw_from5 ? dec_dir[4] : dec_dir[5];
   wire [31:0] sp_pos;
   wire [31:0] hw_pos;

   // Spindle counts every edge, so one encoder line is four counts
   afc_pos_acc u_sp (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_step(sp_step),
      .i_dir(sp_dir),
      .i_clr(pclr_reg[5]),
      .i_inc(20'h0_0001),
      .o_pos(sp_pos)
   ); // [RL16]

   afc_pos_acc u_hw (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_step(hw_step),
      .i_dir(hw_dir),
      .i_clr(pclr_reg[6]),
      .i_inc(20'h0_0001),
      .o_pos(hw_pos)
   );

   // --------------------------------------------------------------------
   // Simultaneous interpolation check on the requested axis mask
   // --------------------------------------------------------------------
   reg illegal;
   reg [2:0] nax;
   integer i;
   always @* begin
      nax = 3'd0;
      for (i = 0; i < 5; i = i + 1)
         nax = nax + {2'b00, move_reg[i]};
      illegal = 1'b0;
      if (nax > 3'd3)
         illegal = 1'b1; // [RL5]
      if (move_reg[3] & move_reg[4])
         illegal = 1'b1; // [RL5]
      if ((move_reg[3] | move_reg[4]) & ((sel == 2'd3) | move_reg[sel]))
         illegal = 1'b1; // [RL5]
      if (move_reg[4] & ~v_on)
         illegal = 1'b1; // [RL6]
   end

   // --------------------------------------------------------------------
   // Pin outputs: registered
   // --------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_axis_move_en <= 5'h00;
         o_interp_illegal <= 1'b0;
         o_axis_inch <= 5'h00;
         o_overspeed <= 6'h00;
      end else begin
         // An illegal mix releases no axis at all rather than a subset
         o_axis_move_en <= illegal ? 5'h00 : move_reg; // [RL5]
         o_interp_illegal <= illegal;
         o_axis_inch <= {cfg_reg[4][`AFC_CFG_INCH], cfg_reg[3][`AFC_CFG_INCH],
            cfg_reg[2][`AFC_CFG_INCH], cfg_reg[1][`AFC_CFG_INCH],
            cfg_reg[0][`AFC_CFG_INCH]}; // [RL13]
         o_overspeed <= err_reg;
      end
   end

   // --------------------------------------------------------------------
   // AXI4-Lite write path: address and data held separately
   // --------------------------------------------------------------------
   assign o_awready = ~aw_full_reg;
   assign o_wready = ~w_full_reg;
   wire do_wr = aw_full_reg & w_full_reg & ~o_bvalid;
   wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0] wbits = w_data_reg & wmask;
   wire hit_ctrl = (aw_addr_reg == `AFC_OFS_CTRL);
   wire hit_move = (aw_addr_reg == `AFC_OFS_MOVE);
   wire hit_stat = (aw_addr_reg == `AFC_OFS_STAT);
   wire hit_pclr = (aw_addr_reg == `AFC_OFS_PCLR);
   wire hit_cfg = (aw_addr_reg >= `AFC_OFS_AXCFG) && (aw_addr_reg < 8'h24) &&
      (aw_addr_reg[1:0] == 2'b00);
   wire [2:0] cfg_idx = aw_addr_reg[4:2] - 3'd4;
   wire wr_ok = hit_ctrl | hit_move | hit_stat | hit_pclr | hit_cfg;
   wire [5:0] err_clr = (do_wr & hit_stat) ? wbits[5:0] : 6'h00;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OK;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
         end
         if (do_wr) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? RESP_OK : RESP_ERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------
   // Register updates; a new overspeed event beats a same-cycle clear
   // --------------------------------------------------------------------
   integer j;
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg <= `AFC_RST_CTRL;
         move_reg <= `AFC_RST_MOVE;
         err_reg <= 6'h00;
         pclr_reg <= 7'h00;
         for (j = 0; j < 5; j = j + 1)
            cfg_reg[j] <= `AFC_RST_CFG;
      end else begin
         err_reg <= (err_reg & ~err_clr) | dec_err; // [RL7] [RL8]
         pclr_reg <= (do_wr & hit_pclr) ? wbits[6:0] : 7'h00;
         if (do_wr && hit_ctrl)
            ctrl_reg <= (ctrl_reg & ~wmask[7:0]) | wbits[7:0];
         if (do_wr && hit_move)
            move_reg <= (move_reg & ~wmask[4:0]) | wbits[4:0];
         if (do_wr && hit_cfg)
            cfg_reg[cfg_idx] <= (cfg_reg[cfg_idx] & ~wmask[15:0]) | wbits[15:0];
      end
   end

   // --------------------------------------------------------------------
   // AXI4-Lite read path: one cycle from address to data
   // --------------------------------------------------------------------
   assign o_arready = ~o_rvalid;
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (i_araddr == `AFC_OFS_CTRL)
         rd_val = {24'h00_0000, ctrl_reg};
      else if (i_araddr == `AFC_OFS_MOVE)
         rd_val = {27'h000_0000, move_reg};
      else if (i_araddr == `AFC_OFS_STAT)
         rd_val = {22'h00_0000, v_on, illegal, 2'b00, err_reg};
      else if (i_araddr == `AFC_OFS_PCLR)
         rd_val = 32'h0000_0000;
      else if ((i_araddr >= `AFC_OFS_AXCFG) && (i_araddr < 8'h24) && (i_araddr[1:0] == 2'b00))
         rd_val = {16'h0000, cfg_reg[i_araddr[4:2] - 3'd4]};
      else if ((i_araddr >= `AFC_OFS_AXPOS) && (i_araddr < 8'h54) && (i_araddr[1:0] == 2'b00))
         rd_val = ax_pos[i_araddr[4:2] - 3'd0];
      else if (i_araddr == `AFC_OFS_SPPOS)
         rd_val = sp_pos;
      else if (i_araddr == `AFC_OFS_HWPOS)
         rd_val = hw_pos;
      else
         rd_ok = 1'b0;
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OK;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_val;
         o_rresp <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule

// [test/afc_chk_sva.sv]
// Port-level assertions and covers for the axis feedback counter
module afc_chk #(
   parameter GAP_SQ = 90,
   parameter GAP_SINE = 720
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_awvalid,
   input wire o_awready,
   input wire i_wvalid,
   input wire o_wready,
   input wire [1:0] o_bresp,
   input wire o_bvalid,
   input wire i_bready,
   input wire i_arvalid,
   input wire o_arready,
   input wire [31:0] o_rdata,
   input wire [1:0] o_rresp,
   input wire o_rvalid,
   input wire i_rready,
   input wire [4:0] o_axis_move_en,
   input wire [4:0] o_axis_inch,
   input wire o_interp_illegal,
   input wire [5:0] o_overspeed
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ------------------------------
   // Bus handshakes
   // ------------------------------
   // Joint address and data hand-off answers two edges later
   property p_wr_lat;
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   // A stalled answer must not move
   property p_b_hold;
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_lat;
      i_arvalid && o_arready |=> o_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_r_hold;
      o_rvalid && !i_rready |=> o_rvalid && $stable({o_rdata, o_rresp});
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block;
      o_rvalid |-> !o_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("second read taken");
   // ------------------------------
   // Axis outputs
   // ------------------------------
   property p_ill_mask;
      o_interp_illegal |-> o_axis_move_en == 5'h00;
   endproperty
   a_ill_mask: assert property (p_ill_mask) else $error("illegal mask moves");
   property p_max3;
      $countones(o_axis_move_en) <= 3 && !(o_axis_move_en[3] && o_axis_move_en[4]);
   endproperty
   a_max3: assert property (p_max3) else $error("too many axes moving");
   // Settings only change through a completed write; allow two output stages
   property p_move_src;
      $changed(o_axis_move_en) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
   endproperty
   a_move_src: assert property (p_move_src) else $error("mask changed alone");
   property p_inch_src;
      $changed(o_axis_inch) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
   endproperty
   a_inch_src: assert property (p_inch_src) else $error("units changed alone");
   // Speed errors are sticky until software clears them
   property p_ovs_clr;
      $fell(|o_overspeed) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
   endproperty
   a_ovs_clr: assert property (p_ovs_clr) else $error("speed error lost");
   c_ill: cover property (o_interp_illegal);
   c_ovs: cover property (|o_overspeed);
   c_slverr: cover property (o_rvalid && i_rready && o_rresp == 2'b10);
   c_bstall: cover property (o_bvalid && !i_bready);
endmodule

bind afc_top afc_chk #(.GAP_SQ(GAP_SQ), .GAP_SINE(GAP_SINE)) u_chk (
   .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
   .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
   .i_rready, .o_axis_move_en, .o_axis_inch, .o_interp_illegal, .o_overspeed
);

// [test/afc_enc_model.sv]
// Behavioural quadrature encoder bank driving the six feedback inputs
module afc_enc_model (
   input wire logic i_clk,
   output logic [5:0] o_a,
   output logic [5:0] o_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase [6];
   // Encoders rest with both channels low
   initial begin
      o_a = 6'h00;
      o_b = 6'h00;
      phase = '{default: 2'h0};
   end
   // One edge per call; gap keeps the edge spacing the counter needs
   task automatic step(input int ch, input logic up, input int gap);
      logic [1:0] p;
      @(posedge i_clk);
      p = up ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
      phase[ch] = p;
      o_a[ch] <= p[0] ^ p[1];
      o_b[ch] <= p[1];
      repeat (gap) @(posedge i_clk);
   endtask
endmodule

// [test/test_axis_feedback_counter.sv]
// Self-checking bench: bus tasks, encoder stimulus, queued response checks
`include "afc_consts.vh"

module test_axis_feedback_counter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GSQ = 8;
   localparam int GSN = 16;
   localparam int GAP = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire [5:0] fb_a, fb_b, ovs;
   wire awready, wready, bvalid, arready, rvalid, illegal;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [4:0] move_en, inch;
   logic [33:0] exp_q [$];
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'h0000_bd4a;
   logic [7:0] res;
   // Interpolation cases: control, requested mask, expected illegal flag
   logic [13:0] itab [11] = '{{8'h00, 5'h07, 1'h0}, {8'h00, 5'h0F, 1'h1},
      {8'h00, 5'h0E, 1'h0}, {8'h00, 5'h09, 1'h1}, {8'h00, 5'h10, 1'h1},
      {8'h05, 5'h11, 1'h0}, {8'h05, 5'h12, 1'h1}, {8'h05, 5'h18, 1'h1},
      {8'h05, 5'h15, 1'h0}, {8'h03, 5'h08, 1'h1}, {8'h03, 5'h07, 1'h0}};
   // Counting modes of X: config bits and counts per four edges
   logic [3:0] ctab [6] = '{4'h0, 4'h2, 4'h0, 4'h1, 4'h9, 4'hB};
   int mtab [6] = '{4, 2, -4, 4, 20, 10};
   int stab [4] = '{8, 0, 4, 8};
   int htab [4] = '{0, 8, 8, 4};

   afc_enc_model enc (.i_clk(clk), .o_a(fb_a), .o_b(fb_b));
   afc_top #(.GAP_SQ(GSQ), .GAP_SINE(GSN)) DUT (
      .i_clk(clk), .i_rst_n(rst_n), .i_fb_a(fb_a), .i_fb_b(fb_b),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .o_axis_move_en(move_en), .o_axis_inch(inch),
      .o_interp_illegal(illegal), .o_overspeed(ovs));

   initial forever #2.5 clk = ~clk;

   // ------------------------------
   // Checking and closing
   // ------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Oldest note is compared with each response as it is handed over
   always @(posedge clk) begin
      if (rst_n && ((bvalid && bready) || (rvalid && rready))) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("unexpected response at %0t", $time);
         end else if (bvalid) chk(34'({bresp, 32'h0000_0000}), exp_q.pop_front());
         else chk(34'({rresp, rdata}), exp_q.pop_front());
      end
   end
   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         $display("unexpected timeout at %0t", $time);
         report_and_stop();
      end
   end
   // ------------------------------
   // Bus tasks; a random stall holds back the response ready
   // ------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0000_0000});
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'($random(seed));
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, d});
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'($random(seed));
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk(34'({move_en, inch, illegal, ovs}), 34'h0_0000_0000);
      rd(`AFC_OFS_CTRL, 32'h0000_0000, 2'b00);
      rd(`AFC_OFS_MOVE, 32'h0000_0000, 2'b00);
      for (int k = 0; k < 5; k++) rd(`AFC_OFS_AXCFG + 8'(4 * k), 32'h0000_0100, 2'b00);
      rd(8'h3C, 32'h0000_0000, 2'b10);
      wr(8'h3C, 32'hFFFF_FFFF, 2'b10);
      // Simultaneous-motion limits and the fifth-axis enable
      foreach (itab[i]) begin
         wr(`AFC_OFS_CTRL, 32'(itab[i][13:6]), 2'b00);
         wr(`AFC_OFS_MOVE, 32'(itab[i][5:1]), 2'b00);
         repeat (3) @(posedge clk);
         chk(34'({illegal, move_en}), 34'({itab[i][0], itab[i][0] ? 5'h00 : itab[i][5:1]}));
         rd(`AFC_OFS_STAT, {22'h0, itab[i][8] && !itab[i][11], itab[i][0], 8'h00}, 2'b00);
      end
      // Each fixed input counts its own axis, inch units on all four
      for (int k = 0; k < 4; k++) begin
         res = 8'($random(seed)) | 8'h01;
         wr(`AFC_OFS_AXCFG + 8'(4 * k), {16'h0, res, 8'h04}, 2'b00);
         repeat (4) enc.step(k, 1'b1, GAP);
         rd(`AFC_OFS_AXPOS + 8'(4 * k), 32'(4 * int'(res)), 2'b00);
      end
      chk(34'(inch), 34'h0_0000_000F);
      // Multiplication, feedback type, extra sine factor and direction on X
      foreach (ctab[i]) begin
         res = 8'($random(seed)) | 8'h01;
         wr(`AFC_OFS_PCLR, 32'h0000_0001, 2'b00);
         wr(`AFC_OFS_AXCFG, {16'h0, res, 4'h0, ctab[i]}, 2'b00);
         repeat (4) enc.step(0, mtab[i] > 0, GAP);
         rd(`AFC_OFS_AXPOS, 32'(mtab[i] * int'(res)), 2'b00);
      end
      chk(34'(inch), 34'h0_0000_000E);
      // Edges too close on Y raise a sticky error, cleared by writing one
      repeat (3) enc.step(1, 1'b1, 2);
      repeat (GAP) @(posedge clk);
      chk(34'(ovs), 34'h0_0000_0002);
      rd(`AFC_OFS_STAT, 32'h0000_0002, 2'b00);
      wr(`AFC_OFS_STAT, 32'h0000_0002, 2'b00);
      rd(`AFC_OFS_STAT, 32'h0000_0000, 2'b00);
      // X is still sine: spacing legal for square is too close here
      repeat (2) enc.step(0, 1'b1, 10);
      repeat (GAP) @(posedge clk);
      chk(34'(ovs), 34'h0_0000_0001);
      // All four routings of inputs five and six; spindle counts every edge
      for (int r = 0; r < 4; r++) begin
         wr(`AFC_OFS_CTRL, 32'(8'h44 | 8'(r << 4)), 2'b00);
         rd(`AFC_OFS_CTRL, 32'(8'h44 | 8'(r << 4)), 2'b00);
         wr(`AFC_OFS_PCLR, 32'h0000_007F, 2'b00);
         repeat (4) enc.step(4, 1'b1, GAP);
         repeat (8) enc.step(5, 1'b1, GAP);
         rd(`AFC_OFS_AXPOS + 8'h10, (r < 2) ? 32'h0000_0004 : 32'h0000_0000, 2'b00);
         rd(`AFC_OFS_SPPOS, 32'(stab[r]), 2'b00);
         rd(`AFC_OFS_HWPOS, 32'(htab[r]), 2'b00);
      end
      repeat (5) @(posedge clk);
      chk(34'(exp_q.size()), 34'h0_0000_0000);
      report_and_stop();
   end
endmodule
